// ==== src/fence_defs.vh ====
// Functional notes
// R1: translator takes byte offset, pitch in tiles, column-major and block-walk selects; here pitch_field comes in 128-byte units and is turned into tiles.
// R2: tile height is 8 rows row-major, 32 column-major, 64 block-walk.
// R3: tile width is 512 bytes row-major, 128 column-major, 64 block-walk.
// R4: tile size is height times width; tile row size is pitch times tile size.
// R5: fenced access first subtracts the region base from the linear offset.
// R6: rebased offset split by tile width; Y and X derived via pitch.
// R7: in-tile offsets are modulo, tile indices are quotients, of height and width.
// R8: tiled offset sums row, column, 16-byte chunk, row-in-tile and byte terms.
// R9: column-major: even row and the row below share one aligned 64-byte line.
// R10: software keeps scanout surfaces linear or row-major, never column-major.
// R11: aperture accesses detect tiling only by fence lookup.
// R12: sixteen independent fence descriptors, each one tiled region.
// R13: internal graphics client accesses ignore every fence.
// R14: per-process graphics space is never untiled by fences.
// R15: descriptor defines a region only while valid; 4KB up to aperture size.
// R16: pitch ranges from one tile width up to 128KB.
// R17: software never programs overlapping valid fence regions.
// R18: each descriptor carries a tile walk field choosing the tile format.
// R19: sixteen 64-bit read/write entries from offset 100000h, reset to zero.
// R20: each access offset is compared against every fence's start and end.
// R21: fence writes wait until pending accesses under the old setup drain.
// R22: fences survive graphics-only reset; cleared only by full chipset reset.
// R23: access matching no valid fence passes through untranslated.
`ifndef FENCE_DEFS_VH
`define FENCE_DEFS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define FENCE_BASE      24'h100000
`define FENCE_END       24'h100080
`define FENCE_COUNT     16
`define ENTRY_RESET     64'h0000000000000000

// ----------------------------------------------------------------
// descriptor fields
// ----------------------------------------------------------------
`define F_VALID         0
`define F_WALK_Y        1
`define F_WALK_W        2
`define F_LO_MSB        31
`define F_LO_LSB        12
`define F_PITCH_MSB     41
`define F_PITCH_LSB     32
`define F_HI_MSB        63
`define F_HI_LSB        44

// ----------------------------------------------------------------
// tile geometry, as log2
// ----------------------------------------------------------------
`define TW_LOG_X        4'h9
`define TW_LOG_Y        4'h7
`define TW_LOG_W        4'h6
`define TH_LOG_X        4'h3
`define TH_LOG_Y        4'h5
`define TH_LOG_W        4'h6
`define TILE_LOG        4'hC
`define CHUNK_LOG       4'h4

`endif

// ==== src/fence_table.v ====
`timescale 1ns/1ps
`include "fence_defs.vh"
module fence_table #(
    parameter N = 16
) (
    input  wire            ref_clk,
    input  wire            rst_n,
    input  wire            wr_en,
    input  wire [3:0]      wr_idx,
    input  wire            wr_hi,
    input  wire [31:0]     wr_data,
    input  wire [3:0]      rd_idx,
    input  wire            rd_hi,
    output reg  [31:0]     rd_data,
    output wire [N*64-1:0] entries
);

reg [63:0] mem [0:N-1];
integer    i;
genvar     g;

// ----------------------------------------------------------------
// storage; only the chipset reset clears it
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        for (i = 0; i < N; i = i + 1) begin
            mem[i] <= `ENTRY_RESET; // R19 R22
        end
        rd_data <= 32'h00000000;
    end else begin
        if (wr_en && wr_hi) begin
            mem[wr_idx][63:32] <= wr_data; // R19
        end else if (wr_en) begin
            mem[wr_idx][31:0] <= wr_data;
        end
        rd_data <= rd_hi ? mem[rd_idx][63:32] : mem[rd_idx][31:0];
    end
end

// all entries are visible at once for the parallel compare
generate
    for (g = 0; g < N; g = g + 1) begin : flat
        assign entries[g*64 +: 64] = mem[g];
    end
endgenerate

endmodule // fence_table

// ==== src/fenced_tile_address_translator.v ====
`timescale 1ns/1ps
`include "fence_defs.vh"
module fenced_tile_address_translator #(
    parameter N = 16
) (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        gfx_rst_n,
    input  wire        mmio_wr,
    input  wire        mmio_rd,
    input  wire [23:0] mmio_addr,
    input  wire [31:0] mmio_wdata,
    output reg         mmio_ready,
    output reg         mmio_rvalid,
    output reg  [31:0] mmio_rdata,
    input  wire        ap_req,
    input  wire [31:0] ap_offset,
    input  wire        ap_internal,
    input  wire        ap_per_process,
    output reg         ap_ready,
    output reg         xl_valid,
    output reg  [31:0] xl_offset,
    output reg         xl_tiled,
    output reg  [3:0]  xl_fence_idx
);

wire [N*64-1:0] entries;
wire [31:0]     rd_data;
wire [31:0]     calc_out;
wire            wr_hit;
wire            rd_hit;
wire            wr_take;
wire            rd_take;
wire            ap_take;
wire            apply;

reg         pend_v;
reg  [3:0]  pend_idx;
reg         pend_hi;
reg  [31:0] pend_data;
reg         rd_v1;
reg         rd_map1;
reg         s1_v;
reg  [31:0] s1_lin;
reg         s1_hit;
reg  [3:0]  s1_idx;
reg  [31:0] s1_base;
reg  [9:0]  s1_pitch;
reg         s1_wy;
reg         s1_ww;
reg         next_ap_ready;

reg         hit;
reg  [3:0]  hit_idx;
reg  [63:0] hit_entry;
reg  [63:0] e;
integer     i;

// ----------------------------------------------------------------
// register access decode
// ----------------------------------------------------------------
assign wr_hit  = (mmio_addr >= `FENCE_BASE) && (mmio_addr < `FENCE_END);
assign rd_hit  = wr_hit;
assign wr_take = mmio_wr && mmio_ready && wr_hit;
assign rd_take = mmio_rd && !mmio_wr;
assign ap_take = ap_req && ap_ready;
// a new bound lands only once nothing is in flight
assign apply   = pend_v && !ap_ready && !s1_v; // R21

always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        pend_v    <= 1'b0;
        pend_idx  <= 4'h0;
        pend_hi   <= 1'b0;
        pend_data <= 32'h00000000;
        mmio_ready <= 1'b0;
    end else begin
        if (wr_take) begin
            pend_v    <= 1'b1; // R21
            pend_idx  <= mmio_addr[6:3];
            pend_hi   <= mmio_addr[2];
            pend_data <= mmio_wdata;
        end else if (apply) begin
            pend_v <= 1'b0;
        end
        mmio_ready <= !(wr_take || (pend_v && !apply));
    end
end

// ----------------------------------------------------------------
// read path; unmapped addresses read as zero
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        rd_v1       <= 1'b0;
        rd_map1     <= 1'b0;
        mmio_rvalid <= 1'b0;
        mmio_rdata  <= 32'h00000000;
    end else begin
        rd_v1       <= rd_take;
        rd_map1     <= rd_take && rd_hit;
        mmio_rvalid <= rd_v1;
        mmio_rdata  <= rd_map1 ? rd_data : 32'h00000000; // R19
    end
end

fence_table #(
    .N (N)
) u_table (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr_en   (apply),
    .wr_idx  (pend_idx),
    .wr_hi   (pend_hi),
    .wr_data (pend_data),
    .rd_idx  (mmio_addr[6:3]),
    .rd_hi   (mmio_addr[2]),
    .rd_data (rd_data),
    .entries (entries)
);

// ----------------------------------------------------------------
// fence lookup; lowest index wins, overlap is software's fault
// ----------------------------------------------------------------
always @* begin
    hit       = 1'b0;
    hit_idx   = 4'h0;
    hit_entry = `ENTRY_RESET;
    e         = `ENTRY_RESET;
    for (i = N - 1; i >= 0; i = i - 1) begin // R12
        e = entries[i*64 +: 64];
        if (e[`F_VALID] // R15
            && ap_offset[31:12] >= e[`F_LO_MSB:`F_LO_LSB] // R20
            && ap_offset[31:12] <= e[`F_HI_MSB:`F_HI_LSB]) begin
            hit       = 1'b1;
            hit_idx   = i[3:0];
            hit_entry = e;
        end
    end
    // internal and per-process accesses never see a fence
    if (ap_internal || ap_per_process) begin // R11 R13 R14
        hit     = 1'b0;
        hit_idx = 4'h0;
    end
end

// ----------------------------------------------------------------
// translation pipeline; graphics reset flushes it, not the table
// ----------------------------------------------------------------
always @* begin
    next_ap_ready = !(wr_take || (pend_v && !apply)); // R21
end

always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        ap_ready <= 1'b0;
        s1_v     <= 1'b0;
        s1_lin   <= 32'h00000000;
        s1_hit   <= 1'b0;
        s1_idx   <= 4'h0;
        s1_base  <= 32'h00000000;
        s1_pitch <= 10'h000;
        s1_wy    <= 1'b0;
        s1_ww    <= 1'b0;
    end else if (!gfx_rst_n) begin
        ap_ready <= 1'b0; // R22
        s1_v     <= 1'b0;
    end else begin
        ap_ready <= next_ap_ready;
        s1_v     <= ap_take;
        if (ap_take) begin
            s1_lin   <= ap_offset;
            s1_hit   <= hit;
            s1_idx   <= hit_idx;
            s1_base  <= {hit_entry[`F_LO_MSB:`F_LO_LSB], 12'h000}; // R5
            s1_pitch <= hit_entry[`F_PITCH_MSB:`F_PITCH_LSB]; // R1
            s1_wy    <= hit_entry[`F_WALK_Y]; // R18
            s1_ww    <= hit_entry[`F_WALK_W]; // R18
        end
    end
end

tile_offset_calc u_calc (
    .lin                 (s1_lin),
    .base                (s1_base),
    .pitch_field         (s1_pitch),
    .column_major_select (s1_wy),
    .block_walk_select   (s1_ww),
    .tiled               (calc_out)
);

always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        xl_valid     <= 1'b0;
        xl_offset    <= 32'h00000000;
        xl_tiled     <= 1'b0;
        xl_fence_idx <= 4'h0;
    end else if (!gfx_rst_n) begin
        xl_valid <= 1'b0; // R22
    end else begin
        xl_valid <= s1_v;
        if (s1_v) begin
            // unfenced offsets go straight through
            xl_offset    <= s1_hit ? calc_out : s1_lin; // R23
            xl_tiled     <= s1_hit;
            xl_fence_idx <= s1_idx;
        end
    end
end

endmodule // fenced_tile_address_translator

// ==== src/tile_offset_calc.v ====
`timescale 1ns/1ps
`include "fence_defs.vh"
module tile_offset_calc (
    input  wire [31:0] lin,
    input  wire [31:0] base,
    input  wire [9:0]  pitch_field,
    input  wire        column_major_select,
    input  wire        block_walk_select,
    output reg  [31:0] tiled
);

reg [3:0]  tw_log;
reg [3:0]  th_log;
reg [10:0] p11;
reg [31:0] pitch;
reg [31:0] reb;
reg [31:0] q;
reg [31:0] rem;
reg [31:0] y;
reg [31:0] x;
reg [31:0] yin;
reg [31:0] xin;
reg [31:0] ytile;
reg [31:0] xtile;
reg [31:0] row_term;

// ----------------------------------------------------------------
// linear to tiled conversion
// ----------------------------------------------------------------
always @* begin
    p11 = {1'b0, pitch_field} + 11'h001;
    // field counts 128-byte units; tiles per row follow from the walk
    if (block_walk_select) begin // R1 R18
        tw_log = `TW_LOG_W; // R3
        th_log = `TH_LOG_W; // R2
        pitch  = {20'h00000, p11, 1'b0}; // R16
    end else if (column_major_select) begin
        tw_log = `TW_LOG_Y; // R3
        th_log = `TH_LOG_Y; // R2
        pitch  = {21'h000000, p11}; // R16
    end else begin
        tw_log = `TW_LOG_X; // R3
        th_log = `TH_LOG_X; // R2
        pitch  = {23'h000000, p11[10:2]}; // R16
    end
    // a row-major pitch below one tile is illegal; avoid divide by zero
    if (pitch == 32'h00000000) begin
        pitch = 32'h00000001;
    end
    reb = lin - base; // R5
    q   = reb >> tw_log; // R6
    rem = reb & ((32'h00000001 << tw_log) - 32'h00000001); // R6
    y   = q / pitch; // R6
    x   = ((q % pitch) << tw_log) + rem; // R6
    yin   = y & ((32'h00000001 << th_log) - 32'h00000001); // R7
    xin   = x & ((32'h00000001 << tw_log) - 32'h00000001); // R7
    ytile = y >> th_log; // R7
    xtile = x >> tw_log; // R7
    row_term = (ytile * pitch) << `TILE_LOG; // R4
    // rows pack in 16-byte chunks, so two rows share a 32-byte span
    tiled = row_term + (xtile << `TILE_LOG)
          + ((xin >> `CHUNK_LOG) << (th_log + `CHUNK_LOG))
          + (yin << `CHUNK_LOG) + {28'h0000000, xin[3:0]}
          + base; // R8 R9
end

endmodule // tile_offset_calc

// ==== test/fenced_tile_address_translator_props.sv ====
`timescale 1ns/1ps
`include "fence_defs.vh"
module fenced_tile_address_translator_props #(
    parameter N = 16
) (
    input logic        ref_clk,
    input logic        rst_n,
    input logic        gfx_rst_n,
    input logic        mmio_wr,
    input logic        mmio_rd,
    input logic [23:0] mmio_addr,
    input logic [31:0] mmio_wdata,
    input logic        mmio_ready,
    input logic        mmio_rvalid,
    input logic [31:0] mmio_rdata,
    input logic        ap_req,
    input logic [31:0] ap_offset,
    input logic        ap_internal,
    input logic        ap_per_process,
    input logic        ap_ready,
    input logic        xl_valid,
    input logic [31:0] xl_offset,
    input logic        xl_tiled,
    input logic [3:0]  xl_fence_idx
);
// ----------------------------------------------------------------
// checks
// ----------------------------------------------------------------
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!rst_n);
wire take = ap_req && ap_ready && gfx_rst_n;
wire fwr  = mmio_wr && mmio_ready && mmio_addr >= `FENCE_BASE
            && mmio_addr < `FENCE_END;

a_read_answer_time: assert property (
    mmio_rd && !mmio_wr |-> ##[1:3] mmio_rvalid) else $error("read late");
a_xl_answer_time: assert property (
    take |-> ##[1:2] xl_valid) else $error("no translation");
a_internal_untiled: assert property (
    take && ap_internal |-> ##[1:2] (xl_valid && !xl_tiled))
    else $error("internal access tiled");
a_process_untiled: assert property (
    take && ap_per_process |-> ##[1:2] (xl_valid && !xl_tiled))
    else $error("per-process access tiled");
a_write_blocks_ap: assert property (
    fwr |=> !mmio_ready && !ap_ready) else $error("write not fenced");
a_flush_bounded: assert property (
    $fell(mmio_ready) |-> ##[1:4] mmio_ready) else $error("write stuck");
a_ready_pair: assert property (
    !mmio_ready |-> !ap_ready) else $error("access during write");
a_result_hold: assert property (
    !xl_valid |-> $stable(xl_offset)) else $error("result moved");
a_gfx_idle: assert property (
    !gfx_rst_n |=> !ap_ready && !xl_valid) else $error("gfx reset ignored");

cover property (fwr);
cover property (take && ap_internal);
cover property (xl_valid && xl_tiled);
endmodule // fenced_tile_address_translator_props

bind fenced_tile_address_translator fenced_tile_address_translator_props
    #(.N(N)) u_props (.*);

// ==== test/host_aperture_model.sv ====
`timescale 1ns/1ps
module host_aperture_model (
    input  wire        ref_clk,
    output reg         ap_req,
    output reg  [31:0] ap_offset,
    output reg         ap_internal,
    output reg         ap_per_process,
    input  wire        ap_ready,
    input  wire        xl_valid,
    input  wire [31:0] xl_offset,
    input  wire        xl_tiled,
    input  wire [3:0]  xl_fence_idx
);
initial begin
    ap_req = 0;
    ap_offset = 0;
    ap_internal = 0;
    ap_per_process = 0;
end
// ----------------------------------------------------------------
// one access at a time; dly idles first to model a slow host
// ----------------------------------------------------------------
task access(input [31:0] a, input in, input pp, input int dly,
            output [31:0] o, output [4:0] ti, output ok);
    int n;
    repeat (dly) @(negedge ref_clk);
    ap_req = 1;
    ap_offset = a;
    ap_internal = in;
    ap_per_process = pp;
    while (ap_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    // released lines go inverse so a stale value is never read as good
    ap_req = 0;
    ap_offset = ~a;
    ap_internal = ~in;
    ap_per_process = ~pp;
    for (n = 0; n < 2 && xl_valid !== 1'b1; n++) @(negedge ref_clk);
    ok = xl_valid;
    o = xl_offset;
    ti = {xl_tiled, xl_fence_idx};
    @(negedge ref_clk);
endtask
endmodule // host_aperture_model

// ==== test/tb_fenced_tile_address_translator.sv ====
`timescale 1ns/1ps
`include "fence_defs.vh"
module tb_fenced_tile_address_translator;
logic ref_clk, rst_n, gfx_rst_n, mmio_wr, mmio_rd, mmio_ready, mmio_rvalid;
logic [23:0] mmio_addr;
logic [31:0] mmio_wdata, mmio_rdata, ap_offset, xl_offset;
logic        ap_req, ap_internal, ap_per_process, ap_ready;
logic        xl_valid, xl_tiled, ok;
logic [3:0]  xl_fence_idx;
logic [31:0] lin, o, lo, hi, b, lo_w[16], hi_w[16];
logic [4:0]  ti;
logic [36:0] e;
int i, k, r, p, pf, cyc, err_count, checked;
int fk[4] = '{0, 5, 7, 15};
int md[4] = '{1, 3, 0, 5};

fenced_tile_address_translator dut (.*);
host_aperture_model host (.*);

initial begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
end
always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
        err_count++;
        final_report;
    end
end
// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
task chk(input [31:0] g, input [31:0] x);
    checked++;
    if (g !== x) begin
        err_count++;
        $display("wrong value t=%0t got=%h exp=%h", $time, g, x);
    end
endtask
task wr(input [23:0] a, input [31:0] d);
    while (mmio_ready !== 1'b1) @(negedge ref_clk);
    mmio_wr = 1;
    mmio_addr = a;
    mmio_wdata = d;
    @(negedge ref_clk);
    mmio_wr = 0;
    mmio_addr = ~a;
    mmio_wdata = ~d;
    @(negedge ref_clk);
endtask
task rd(input [23:0] a, input [31:0] x);
    int n;
    mmio_rd = 1;
    mmio_addr = a;
    @(negedge ref_clk);
    mmio_rd = 0;
    mmio_addr = ~a;
    for (n = 0; n < 3 && mmio_rvalid !== 1'b1; n++) @(negedge ref_clk);
    chk({31'h0, mmio_rvalid}, 32'h1);
    chk(mmio_rdata, x);
    @(negedge ref_clk);
endtask
// {tiled, index, offset}; lowest matching fence wins
function [36:0] expect_xl(input [31:0] a, input byp);
    int j, tw, th, pp, f, bb, q, y, x;
    expect_xl = {5'h00, a};
    for (j = 15; j >= 0; j--)
        if (!byp && lo_w[j][0] && a[31:12] >= lo_w[j][31:12]
            && a[31:12] <= hi_w[j][31:12]) begin
            tw = lo_w[j][2] ? 64 : lo_w[j][1] ? 128 : 512;
            th = lo_w[j][2] ? 64 : lo_w[j][1] ? 32 : 8;
            f = hi_w[j][9:0] + 1;
            pp = lo_w[j][2] ? 2 * f : lo_w[j][1] ? f : (f < 4 ? 1 : f / 4);
            bb = {lo_w[j][31:12], 12'h000};
            q = (a - bb) / tw;
            x = (q % pp) * tw + (a - bb) % tw;
            y = q / pp;
            expect_xl = {1'b1, j[3:0], bb + pp * tw * th * (y / th)
                + tw * th * (x / tw) + th * 16 * ((x % tw) / 16)
                + (y % th) * 16 + x % 16};
        end
endfunction
task final_report;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
// ----------------------------------------------------------------
// main sequence
// ----------------------------------------------------------------
initial begin
    {rst_n, mmio_wr, mmio_rd, mmio_addr, mmio_wdata} = 0;
    gfx_rst_n = 1;
    cyc = 0;
    r = $urandom(7);
    repeat (12) @(negedge ref_clk);
    rst_n = 1;
    repeat (3) @(negedge ref_clk);
    for (k = 0; k < 32; k++) begin
        rd(`FENCE_BASE + 4 * k, 32'h0);
        lo_w[k / 2] = 0;
        hi_w[k / 2] = 0;
    end
    wr(24'h100080, 32'hFFFFFFFF);
    rd(24'h100080, 32'h0);
    // disjoint 1MB regions, one per walk, plus one left invalid
    for (i = 0; i < 4; i++) begin
        k = fk[i];
        b = 32'h0100_0000 + k * 32'h0010_0000;
        pf = md[i] == 1 ? $urandom_range(1, 8) * 4 - 1 :
             md[i] == 3 ? $urandom_range(0, 15) : $urandom_range(0, 7);
        lo_w[k] = b | md[i];
        hi_w[k] = {b[31:12] + 20'h000FF, 2'b00, pf[9:0]};
        wr(`FENCE_BASE + 8 * k, lo_w[k]);
        wr(`FENCE_BASE + 8 * k + 4, hi_w[k]);
        rd(`FENCE_BASE + 8 * k, lo_w[k]);
        rd(`FENCE_BASE + 8 * k + 4, hi_w[k]);
    end
    for (i = 0; i < 300; i++) begin
        r = $urandom_range(0, 4);
        b = r == 4 ? 32'h0110_0000 : 32'h0100_0000 + fk[r] * 32'h10_0000;
        lin = b + (i < 10 ? (i % 2) * 32'hFFFFF : $urandom_range(0, 32'hFFFFF));
        k = $urandom_range(0, 7) == 0;
        host.access(lin, k & i, k & ~i, i % 3, o, ti, ok);
        e = expect_xl(lin, k[0]);
        chk({26'h0, ok, ti}, {26'h0, 1'b1, e[36:32]});
        chk(o, e[31:0]);
    end
    // column-major: an even row and the one below share a 64-byte line
    b = 32'h0150_0000;
    p = hi_w[5][9:0] + 1;
    for (i = 0; i < 4; i++) begin
        lin = b + 2 * i * p * 128 + $urandom_range(0, p * 128 - 1);
        host.access(lin, 1'b0, 1'b0, 0, o, ti, ok);
        host.access(lin + p * 128, 1'b0, 1'b0, 0, lo, ti, ok);
        chk({6'h00, o[31:6]}, {6'h00, lo[31:6]});
    end
    gfx_rst_n = 0;
    @(negedge ref_clk);
    gfx_rst_n = 1;
    repeat (2) @(negedge ref_clk);
    lin = 32'h0100_0240;
    host.access(lin, 1'b0, 1'b0, 0, o, ti, ok);
    e = expect_xl(lin, 1'b0);
    chk(o, e[31:0]);
    rd(`FENCE_BASE, lo_w[0]);
    rst_n = 0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1;
    repeat (3) @(negedge ref_clk);
    rd(`FENCE_BASE, 32'h0);
    final_report;
end
endmodule // tb_fenced_tile_address_translator
